//--- hw/spmc_idle_timer.sv
`timescale 1ns/1ps
module spmc_idle_timer #(
	parameter int unsigned TICK_CYC = spmc_pkg::IDLE_TICK_CYC
) (
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic       en,
	input  wire logic       energy,
	input  wire logic [7:0] thr,
	output logic            expired
);
	import spmc_pkg::*;

	logic [31:0] tick_cnt_r;
	logic [8:0]  idle_cnt_r;
	logic        tick;

	assign tick = (tick_cnt_r >= TICK_CYC - 1);

	always_ff @(posedge mclk) begin
		if (!nrst || !en || energy || tick) begin
			tick_cnt_r <= '0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h1;
		end
	end

	// ninth bit lets the count pass the largest threshold and then saturate
	always_ff @(posedge mclk) begin
		if (!nrst || !en || energy) begin
			idle_cnt_r <= '0;
		end else if (tick && idle_cnt_r != 9'h1FF) begin
			idle_cnt_r <= idle_cnt_r + 9'h001;
		end
	end

	assign expired = en && !energy && (idle_cnt_r > {1'b0, thr});

	chk_idle_restart: assert property (@(posedge mclk) disable iff (!nrst)
		energy |=> idle_cnt_r == 9'h000)
		else $error("idle count not restarted by energy");

endmodule : spmc_idle_timer

//--- hw/spmc_link_pulse.sv
`timescale 1ns/1ps
module spmc_link_pulse #(
	parameter int unsigned PERIOD_CYC = spmc_pkg::LINK_PULSE_PERIOD_CYC
) (
	input  wire logic mclk,
	input  wire logic nrst,
	input  wire logic en,
	output logic      pulse
);
	import spmc_pkg::*;

	logic [31:0] cnt_r;
	logic        pulse_r;

	always_ff @(posedge mclk) begin
		if (!nrst || !en || cnt_r >= PERIOD_CYC - 1) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 32'h1;
		end
	end

	// pulse is cut short if the line wakes up mid-pulse
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pulse_r <= 1'b0;
		end else begin
			pulse_r <= en && (cnt_r < LINK_PULSE_WIDTH_CYC);
		end
	end

	assign pulse = pulse_r;

	chk_pulse_width: assert property (@(posedge mclk) disable iff (!nrst || !en)
		$rose(pulse_r) |-> ##11 pulse_r ##1 !pulse_r)
		else $error("link pulse width is not 12 cycles");

endmodule : spmc_link_pulse

//--- hw/spmc_top.sv
// Functional notes
// - The two-bit mode field picks normal, energy detect, soft power-down or power saving.
// - After reset the mode field is zero so the block starts in normal operation.
// - Normal mode runs the PLL clocks, powers PHY and MAC and opens the host interface.
// - Energy detect mode without cable energy sends 120 ns link pulses once per second.
// - Energy detect mode sleeps once no energy has been seen longer than the idle threshold.
// - The low power state turns off PLL, MAC, host interface and all PHY but energy detect.
// - Cable energy in the low power state brings the PHY back to its normal power state.
// - Mode code 10 stops all PLL clocks and turns off all PHYs and MACs.
// - Any host access in soft power-down wakes to normal mode and resets every register.
// - Power saving with auto-negotiation on and no cable keeps PLL, MAC, registers and host.
// - Power saving keeps the transmitter, drops the unused receiver, restores it on activity.
// - A PHY port is powered down when its control bit 3 or its PHY control bit 11 is set.
//
// Local design decisions: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module spmc_top #(
	parameter int unsigned LINK_PULSE_PERIOD_CYC = spmc_pkg::LINK_PULSE_PERIOD_CYC,
	parameter int unsigned IDLE_TICK_CYC         = spmc_pkg::IDLE_TICK_CYC
) (
	input  wire logic                                   mclk,
	input  wire logic                                   nrst,
	input  wire logic [spmc_pkg::ADDR_W-1:0]            avs_address,
	input  wire logic                                   avs_read,
	input  wire logic                                   avs_write,
	input  wire logic [spmc_pkg::DATA_W-1:0]            avs_writedata,
	input  wire logic [3:0]                             avs_byteenable,
	output logic      [spmc_pkg::DATA_W-1:0]            avs_readdata,
	output logic                                        avs_waitrequest,
	input  wire spmc_pkg::spmc_line_t                   line,
	input  wire logic [spmc_pkg::NUM_PORTS-1:0][15:0]   phy_ctrl0,
	output spmc_pkg::spmc_pwr_t                         pwr,
	output logic      [spmc_pkg::NUM_PORTS-1:0]         port_pd,
	output logic                                        link_pulse,
	output logic                                        int_reset
);
	import spmc_pkg::*;

	spmc_mode_t                    mode_r;
	logic [7:0]                    sleep_r;
	logic [NUM_PORTS-1:0][7:0]     ctrl13_r;
	spmc_state_t                   state_r;
	spmc_state_t                   state_nxt;
	spmc_pwr_t                     pwr_r;
	spmc_pwr_t                     pwr_nxt;
	logic [NUM_PORTS-1:0]          port_pd_r;
	logic                          wait_r;
	logic [DATA_W-1:0]             rdata_r;
	logic [DATA_W-1:0]             rd_val;
	logic                          int_reset_r;
	logic                          req;
	logic                          take;
	logic                          wr_lane0;
	logic                          wake;
	logic                          in_ed;
	logic                          idle_expired;

	// ---------------- bus slave ----------------
	// one wait cycle per access: the request is seen, then answered
	assign req      = avs_read | avs_write;
	assign take     = req & ~wait_r;
	assign wr_lane0 = take & avs_write & avs_byteenable[0];
	assign wake     = take & (state_r == ST_SOFT_PD);

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			wait_r <= 1'b1;
		end else begin
			wait_r <= ~(req & wait_r);
		end
	end

	always_comb begin
		rd_val = '0;
		if (addr_is(avs_address, IDX_PWR_MODE)) begin
			rd_val[MODE_MSB:MODE_LSB] = mode_r;
		end
		if (addr_is(avs_address, IDX_SLEEP_TIME)) begin
			rd_val[7:0] = sleep_r;
		end
		if (addr_is(avs_address, IDX_STATUS)) begin
			rd_val[STAT_STATE_MSB:STAT_STATE_LSB] = state_r;
			rd_val[STAT_PD_MSB:STAT_PD_LSB]       = port_pd_r;
		end
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (addr_is(avs_address, IDX_PORT_CTRL13[p])) begin
				rd_val[7:0] = ctrl13_r[p];
			end
		end
	end

	// a wake-up access is a dummy: it reads zero
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			rdata_r <= '0;
		end else if (avs_read && wait_r) begin
			rdata_r <= (state_r == ST_SOFT_PD) ? '0 : rd_val;
		end
	end

	// ---------------- registers ----------------
	always_ff @(posedge mclk) begin
		if (!nrst || wake) begin
			mode_r <= MODE_RST;
		end else if (wr_lane0 && addr_is(avs_address, IDX_PWR_MODE)) begin
			mode_r <= spmc_mode_t'(avs_writedata[MODE_MSB:MODE_LSB]);
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst || wake) begin
			sleep_r <= SLEEP_RST;
		end else if (wr_lane0 && addr_is(avs_address, IDX_SLEEP_TIME)) begin
			sleep_r <= avs_writedata[7:0];
		end
	end

	always_ff @(posedge mclk) begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (!nrst || wake) begin
				ctrl13_r[p] <= CTRL13_RST;
			end else if (wr_lane0 && addr_is(avs_address, IDX_PORT_CTRL13[p])) begin
				ctrl13_r[p] <= avs_writedata[7:0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			int_reset_r <= 1'b0;
		end else begin
			int_reset_r <= wake;
		end
	end

	// ---------------- power state ----------------
	always_comb begin
		state_nxt = state_r;
		unique case (mode_r)
			MODE_NORMAL: begin
				state_nxt = ST_NORMAL;
			end
			MODE_ENERGY: begin
				if (state_r == ST_ED_SLEEP) begin
					state_nxt = line.energy ? ST_ED_AWAKE : ST_ED_SLEEP;
				end else begin
					state_nxt = idle_expired ? ST_ED_SLEEP : ST_ED_AWAKE;
				end
			end
			MODE_SOFT_PD: begin
				state_nxt = ST_SOFT_PD;
			end
			MODE_PWR_SAVE: begin
				state_nxt = ST_PWR_SAVE;
			end
		endcase
		if (wake) begin
			state_nxt = ST_NORMAL;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state_r <= ST_NORMAL;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_comb begin
		pwr_nxt = PWR_ALL_ON;
		unique case (state_r)
			ST_NORMAL, ST_ED_AWAKE: begin
				pwr_nxt = PWR_ALL_ON;
			end
			ST_ED_SLEEP: begin
				pwr_nxt         = PWR_ALL_OFF;
				pwr_nxt.edet_en = 1'b1;
			end
			ST_SOFT_PD: begin
				pwr_nxt = PWR_ALL_OFF;
			end
			ST_PWR_SAVE: begin
				// receiver back on as soon as a cable or far-end activity shows up
				pwr_nxt.phy_rx_en = ~(line.aneg_en & ~line.energy);
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pwr_r <= PWR_ALL_ON;
		end else begin
			pwr_r <= pwr_nxt;
		end
	end

	// PHY control bit 11 comes from the management block outside
	always_ff @(posedge mclk) begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (!nrst) begin
				port_pd_r[p] <= 1'b0;
			end else begin
				port_pd_r[p] <= ctrl13_r[p][PORT_PD_BIT] | phy_ctrl0[p][PHY_PD_BIT];
			end
		end
	end

	// ---------------- energy detect helpers ----------------
	assign in_ed = (state_r == ST_ED_AWAKE) || (state_r == ST_ED_SLEEP);

	spmc_idle_timer #(
		.TICK_CYC (IDLE_TICK_CYC)
	) u_idle (
		.mclk    (mclk),
		.nrst    (nrst),
		.en      (state_r == ST_ED_AWAKE),
		.energy  (line.energy),
		.thr     (sleep_r),
		.expired (idle_expired)
	);

	spmc_link_pulse #(
		.PERIOD_CYC (LINK_PULSE_PERIOD_CYC)
	) u_pulse (
		.mclk  (mclk),
		.nrst  (nrst),
		.en    (in_ed && !line.energy),
		.pulse (link_pulse)
	);

	assign avs_waitrequest = wait_r;
	assign avs_readdata    = rdata_r;
	assign pwr             = pwr_r;
	assign port_pd         = port_pd_r;
	assign int_reset       = int_reset_r;

	// ---------------- checks ----------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	chk_mode_reset: assert property (
		!$past(nrst) |-> mode_r == MODE_NORMAL && state_r == ST_NORMAL && pwr_r == PWR_ALL_ON)
		else $error("block did not start in normal mode");

	chk_mode_decode: assert property (
		(mode_r == MODE_PWR_SAVE && !wake) |=> state_r == ST_PWR_SAVE)
		else $error("mode code 11 did not select power saving");

	chk_normal_on: assert property (
		state_r == ST_NORMAL |=> pwr_r == PWR_ALL_ON)
		else $error("normal mode not fully powered");

	chk_sleep_entry: assert property (
		(state_r == ST_ED_AWAKE && mode_r == MODE_ENERGY && idle_expired && !wake)
		|=> state_r == ST_ED_SLEEP)
		else $error("idle expiry did not enter low power");

	chk_sleep_off: assert property (
		state_r == ST_ED_SLEEP |=> !pwr_r.pll_en && !pwr_r.mac_en && !pwr_r.host_en
			&& !pwr_r.phy_tx_en && !pwr_r.phy_rx_en && pwr_r.edet_en)
		else $error("low power state left something on");

	chk_energy_wake: assert property (
		(state_r == ST_ED_SLEEP && mode_r == MODE_ENERGY && line.energy)
		|=> state_r == ST_ED_AWAKE ##1 pwr_r == PWR_ALL_ON)
		else $error("energy did not restore normal power");

	chk_soft_off: assert property (
		state_r == ST_SOFT_PD |=> pwr_r == PWR_ALL_OFF)
		else $error("soft power-down left something on");

	chk_soft_wake: assert property (
		wake |=> int_reset_r && mode_r == MODE_NORMAL && sleep_r == SLEEP_RST
			&& state_r == ST_NORMAL ##1 !int_reset_r)
		else $error("soft power-down access did not wake and reset");

	chk_psave_rx: assert property (
		(state_r == ST_PWR_SAVE) |=> pwr_r.phy_tx_en && pwr_r.pll_en && pwr_r.mac_en
			&& pwr_r.host_en && (pwr_r.phy_rx_en == ($past(line.energy) || !$past(line.aneg_en))))
		else $error("power saving receiver control wrong");

	chk_port_pd: assert property (
		##1 port_pd_r[0] == ($past(ctrl13_r[0][PORT_PD_BIT]) || $past(phy_ctrl0[0][PHY_PD_BIT])))
		else $error("port power-down does not follow its sources");

	chk_port_pd_hi: assert property (
		##1 port_pd_r[1] == ($past(ctrl13_r[1][PORT_PD_BIT]) || $past(phy_ctrl0[1][PHY_PD_BIT])))
		else $error("port 1 power-down does not follow its sources");

	chk_bus_answer: assert property (
		(req && wait_r) |=> !wait_r)
		else $error("bus request not answered after one wait cycle");

	chk_wait_once: assert property (
		!wait_r |=> wait_r)
		else $error("waitrequest low for more than one cycle");

	chk_pulse_normal: assert property (
		state_r == ST_NORMAL |=> !link_pulse)
		else $error("link pulse seen outside energy detect");

endmodule : spmc_top

//--- pkg/spmc_pkg.sv
package spmc_pkg;

	// clock and timing
	localparam int unsigned CLK_PERIOD_NS         = 10;
	localparam int unsigned LINK_PULSE_WIDTH_NS   = 120;
	localparam int unsigned LINK_PULSE_WIDTH_CYC  =
		(LINK_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LINK_PULSE_PERIOD_S   = 1;
	localparam int unsigned LINK_PULSE_PERIOD_CYC =
		LINK_PULSE_PERIOD_S * 1_000_000_000 / CLK_PERIOD_NS;
	// one unit of the go-sleep threshold
	localparam int unsigned IDLE_TICK_US          = 1000;
	localparam int unsigned IDLE_TICK_CYC         = IDLE_TICK_US * 1000 / CLK_PERIOD_NS;

	localparam int unsigned NUM_PORTS = 2;
	localparam int unsigned ADDR_W    = 8;
	localparam int unsigned DATA_W    = 32;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_PWR_MODE   = 8'h0E;
	localparam logic [7:0] IDX_SLEEP_TIME = 8'h0F;
	localparam logic [7:0] IDX_STATUS     = 8'h10;
	localparam logic [NUM_PORTS-1:0][7:0] IDX_PORT_CTRL13 = {8'h2D, 8'h1D};

	// field positions
	localparam int unsigned MODE_LSB       = 3;
	localparam int unsigned MODE_MSB       = 4;
	localparam int unsigned PORT_PD_BIT    = 3;
	localparam int unsigned PHY_PD_BIT     = 11;
	localparam int unsigned STAT_STATE_LSB = 0;
	localparam int unsigned STAT_STATE_MSB = 4;
	localparam int unsigned STAT_PD_LSB    = 5;
	localparam int unsigned STAT_PD_MSB    = 6;

	typedef enum logic [1:0] {
		MODE_NORMAL   = 2'h0,
		MODE_ENERGY   = 2'h1,
		MODE_SOFT_PD  = 2'h2,
		MODE_PWR_SAVE = 2'h3
	} spmc_mode_t;

	typedef enum logic [4:0] {
		ST_NORMAL   = 5'h01,
		ST_ED_AWAKE = 5'h02,
		ST_ED_SLEEP = 5'h04,
		ST_SOFT_PD  = 5'h08,
		ST_PWR_SAVE = 5'h10
	} spmc_state_t;

	typedef struct packed {
		logic pll_en;
		logic mac_en;
		logic host_en;
		logic phy_tx_en;
		logic phy_rx_en;
		logic edet_en;
	} spmc_pwr_t;

	typedef struct packed {
		logic energy;
		logic aneg_en;
	} spmc_line_t;

	// reset values
	localparam spmc_mode_t MODE_RST   = MODE_NORMAL;
	localparam logic [7:0] SLEEP_RST  = 8'h50;
	localparam logic [7:0] CTRL13_RST = 8'h00;
	localparam spmc_pwr_t  PWR_ALL_ON = 6'h3F;
	localparam spmc_pwr_t  PWR_ALL_OFF = 6'h00;

	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		return a == {idx[5:0], 2'b00};
	endfunction : addr_is

endpackage : spmc_pkg

//--- testbench/spmc_line_model.sv
`timescale 1ns/1ps
// cable side: energy follows the plug one cycle late, like a squelch detector
module spmc_line_model (
	input  wire logic            mclk,
	input  wire logic            plug,
	input  wire logic            aneg,
	output spmc_pkg::spmc_line_t line
);
	import spmc_pkg::*;
	always_ff @(posedge mclk) begin
		line.energy  <= plug;
		line.aneg_en <= aneg;
	end
endmodule : spmc_line_model

//--- testbench/switch_power_mode_control_test.sv
`timescale 1ns/1ps
module switch_power_mode_control_test;
	import spmc_pkg::*;
	logic             mclk, nrst, rd, wr, waitreq, plug, aneg, lp, irst;
	logic [7:0]       addr;
	logic [31:0]      wdata, rdata, rv;
	logic [1:0][15:0] pc0;
	logic [1:0]       ppd;
	logic [3:0]       be;
	spmc_line_t       line;
	spmc_pwr_t        pwr;
	int               err_total, cmp_count, k, n;
	int               rst_seen = 0;

	spmc_top #(.LINK_PULSE_PERIOD_CYC(100), .IDLE_TICK_CYC(4)) dut (
		.mclk(mclk), .nrst(nrst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
		.avs_waitrequest(waitreq), .line(line), .phy_ctrl0(pc0), .pwr(pwr),
		.port_pd(ppd), .link_pulse(lp), .int_reset(irst)
	);
	spmc_line_model cable (.mclk(mclk), .plug(plug), .aneg(aneg), .line(line));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk) if (irst === 1'b1) rst_seen++;

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk

	task cyc(input int c);
		repeat (c) @(posedge mclk);
	endtask : cyc

	// one avalon access; read data lands in rv at the edge with waitrequest low
	task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		int t;
		@(posedge mclk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= {24'h0, d};
		t = 0;
		do begin
			@(posedge mclk);
			t++;
		end while (waitreq !== 1'b0);
		rv = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		chk("wait_cycles", t, 32'd2);
	endtask : xfer

	task t_reset;
		xfer(0, 8'h38, 0); chk("mode", rv, 32'h0);
		xfer(0, 8'h40, 0); chk("state", rv, 32'h01);
		chk("pwr", 32'(pwr), 32'h3F);
		xfer(0, 8'h3C, 0); chk("sleep_thr", rv, 32'h50);
		$display("test reset done");
	endtask : t_reset

	task automatic t_modes;
		logic [1:0] mc [3] = '{2'h1, 2'h3, 2'h0};
		logic [4:0] se [3] = '{5'h02, 5'h10, 5'h01};
		aneg <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			xfer(1, 8'h38, {3'h0, mc[i], 3'h0});
			xfer(0, 8'h38, 0); chk("mode", rv, {27'h0, mc[i], 3'h0});
			xfer(0, 8'h40, 0); chk("state", rv & 32'h1F, {27'h0, se[i]});
		end
		$display("test modes done");
	endtask : t_modes

	task t_energy;
		xfer(1, 8'h3C, 8'h02);
		xfer(1, 8'h38, 8'h08);
		// short gaps in energy must keep restarting the idle count
		for (int i = 0; i < 6; i++) begin
			plug <= 1'b0;
			cyc(6);
			plug <= 1'b1;
			cyc(2);
		end
		xfer(0, 8'h40, 0); chk("state", rv & 32'h1F, 32'h02);
		plug <= 1'b0;
		k = 0;
		while (lp !== 1'b1 && k < 300) begin cyc(1); k++; end
		n = 0;
		while (lp === 1'b1 && n < 300) begin cyc(1); n++; end
		chk("pulse_high", n, 32'd12);
		n = 0;
		while (lp !== 1'b1 && n < 300) begin cyc(1); n++; end
		chk("pulse_low", n, 32'd88);
		xfer(0, 8'h40, 0); chk("state", rv & 32'h1F, 32'h04);
		chk("pwr", 32'(pwr), 32'h01);
		plug <= 1'b1;
		cyc(4);
		chk("pwr", 32'(pwr), 32'h3F);
		chk("link_pulse", {31'h0, lp}, 32'h0);
		xfer(1, 8'h38, 8'h00);
		$display("test energy done");
	endtask : t_energy

	task t_softpd;
		xfer(1, 8'h3C, 8'h33);
		xfer(1, 8'h38, 8'h10);
		cyc(3);
		chk("pwr", 32'(pwr), 32'h00);
		n = rst_seen;
		xfer(0, 8'h40, 0); chk("dummy_read", rv, 32'h0);
		cyc(3);
		chk("int_reset", rst_seen - n, 32'd1);
		xfer(0, 8'h38, 0); chk("mode", rv, 32'h0);
		xfer(0, 8'h3C, 0); chk("sleep_thr", rv, 32'h50);
		chk("pwr", 32'(pwr), 32'h3F);
		$display("test soft power-down done");
	endtask : t_softpd

	task t_psave;
		aneg <= 1'b1;
		plug <= 1'b0;
		xfer(1, 8'h3C, 8'h21);
		xfer(1, 8'h38, 8'h18);
		cyc(4);
		chk("pwr", 32'(pwr) & 32'h3E, 32'h3C);
		xfer(0, 8'h3C, 0); chk("sleep_thr", rv, 32'h21);
		plug <= 1'b1;
		cyc(4);
		chk("pwr", 32'(pwr) & 32'h3E, 32'h3E);
		xfer(1, 8'h38, 8'h00);
		xfer(0, 8'h40, 0); chk("state", rv & 32'h1F, 32'h01);
		$display("test power saving done");
	endtask : t_psave

	task t_port;
		xfer(1, 8'h74, 8'h08);
		cyc(3);
		chk("port_pd", {30'h0, ppd}, 32'h1);
		pc0[1][11] <= 1'b1;
		cyc(3);
		chk("port_pd", {30'h0, ppd}, 32'h3);
		xfer(0, 8'h40, 0); chk("status_pd", (rv >> 5) & 32'h3, 32'h3);
		xfer(1, 8'h74, 8'h00);
		pc0[1][11] <= 1'b0;
		cyc(3);
		chk("port_pd", {30'h0, ppd}, 32'h0);
		// a misaligned address hits nothing
		xfer(1, 8'h39, 8'h18);
		xfer(0, 8'h38, 0); chk("mode", rv, 32'h0);
		xfer(0, 8'h39, 0); chk("unmapped", rv, 32'h0);
		// a write without lane 0 enabled is dropped
		be <= 4'hE;
		xfer(1, 8'h38, 8'h18);
		be <= 4'hF;
		xfer(0, 8'h38, 0); chk("mode_be", rv, 32'h0);
		$display("test port power-down done");
	endtask : t_port

	task complete_run;
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		complete_run;
	end

	initial begin
		nrst = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		plug = 1'b1;
		aneg = 1'b0;
		pc0 = '0;
		be = 4'hF;
		err_total = 0;
		cmp_count = 0;
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		t_reset;
		t_modes;
		t_energy;
		t_softpd;
		t_psave;
		t_port;
		complete_run;
	end
endmodule : switch_power_mode_control_test
